// File: hdl/csba_pkg.sv
// csba_pkg: constants and types for the cache system-side bus arbiter
// assumes a single 100 MHz clock domain
package csba_pkg;
	localparam int unsigned CSBA_ADDR_W_DEF = 32;
	localparam int unsigned CSBA_DATA_W_DEF = 32;
	localparam int unsigned CSBA_IDX_W_DEF  = 8;
	localparam int unsigned CSBA_IDX_LO     = 2;
	localparam logic        CSBA_RST_LVL    = 1'b0;
	localparam logic        CSBA_MODE_MASTER = 1'b1;
	typedef enum logic [1:0] {
		CSBA_OWN,
		CSBA_DRAIN,
		CSBA_GRANTED
	} csba_mst_e;
	typedef enum logic [1:0] {
		CSBA_IDLE,
		CSBA_REQ,
		CSBA_OWNED
	} csba_slv_e;
endpackage

// File: hdl/csba_arbiter.sv
// csba_arbiter: system-side bus arbitration and snoop invalidation
// assumes synchronous inputs; directory lookup is done outside this block, which drives only the index and compares the tag
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RL1: in master mode another master raises the external request to ask for the bus
// RL2: master mode releases bus after current cycle, then raises grant
// RL3: processor-side bus keeps running while another master owns system bus
// RL4: master or slave mode comes from a static strap pin
// RL5: in slave mode request is an output and grant an input
// RL6: slave mode drives system bus only after request then grant
// RL7: system bus carries full address, data and control, run concurrently
// RL8: when not master, watch system writes by others and look up address
// RL9: a snoop hit invalidates the matching directory entry
// RL10: request held until grant and during ownership; grant dropped after request
module csba_arbiter
	import csba_pkg::*;
#(
	parameter int unsigned ADDR_W = CSBA_ADDR_W_DEF,
	parameter int unsigned DATA_W = CSBA_DATA_W_DEF,
	parameter int unsigned IDX_W  = CSBA_IDX_W_DEF
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              modeStrap,
	input  wire logic              extBusRequestIn,
	output logic                   extBusRequestOut,
	output logic                   extBusRequestOe_b,
	input  wire logic              extBusGrantIn,
	output logic                   extBusGrantOut,
	output logic                   extBusGrantOe_b,
	input  wire logic              cacheCycReq,
	input  wire logic              cacheCycWrite,
	input  wire logic [ADDR_W-1:0] cacheCycAddr,
	input  wire logic [DATA_W-1:0] cacheCycWdata,
	output logic                   cacheCycDone,
	output logic [DATA_W-1:0]      cacheCycRdata,
	output logic                   cpuBusGrant,
	output logic [ADDR_W-1:0]      sysAddrOut,
	output logic [DATA_W-1:0]      sysDataOut,
	input  wire logic [DATA_W-1:0] sysDataIn,
	output logic                   sysDataOe_b,
	output logic                   sysStrobeOut,
	output logic                   sysWriteOut,
	output logic                   sysCtlOe_b,
	input  wire logic              sysReady,
	input  wire logic              sysStrobeIn,
	input  wire logic              sysWriteIn,
	input  wire logic [ADDR_W-1:0] sysAddrIn,
	input  wire logic [ADDR_W-1:0] dirTag,
	input  wire logic              dirValid,
	output logic [IDX_W-1:0]       dirIdx,
	output logic                   dirInvalidate,
	output logic [IDX_W-1:0]       dirInvalIdx
);
	// byte-lane bits sit below the index field and never pick an entry
	localparam int unsigned IDX_LO = CSBA_IDX_LO;

	logic      rstMeta_r;
	logic      rstSync_r;
	logic      modeMaster_r;
	logic      modeValid_r;
	csba_mst_e mstState_r;
	csba_slv_e slvState_r;
	logic      cycActive_r;
	logic      cycWrite_r;
	logic      snoopPend_r;
	logic [ADDR_W-1:0] snoopAddr_r;
	logic      ownBus;
	logic      cycStart;

	function automatic logic [IDX_W-1:0] idxOf(input logic [ADDR_W-1:0] a);
		return a[IDX_LO +: IDX_W];
	endfunction

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_r <= CSBA_RST_LVL;
			rstSync_r <= CSBA_RST_LVL;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	// strap caught once after reset release, then frozen
	// a strap moved later is ignored until the next reset
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			modeMaster_r <= CSBA_MODE_MASTER;
			modeValid_r  <= 1'b0;
		end else if (!modeValid_r) begin
			modeMaster_r <= modeStrap; // RL4
			modeValid_r  <= 1'b1;
		end
	end

	// master mode: wait for the running cycle to end before granting
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			mstState_r <= CSBA_OWN;
		end else if (!modeMaster_r || !modeValid_r) begin
			mstState_r <= CSBA_OWN;
		end else begin
			unique case (mstState_r)
			CSBA_OWN:
				if (extBusRequestIn) begin // RL1
					mstState_r <= CSBA_DRAIN;
				end
			// a cycle already on the bus is finished, never cut short
			CSBA_DRAIN:
				if (!cycActive_r || sysReady) begin // RL2
					mstState_r <= CSBA_GRANTED;
				end
			CSBA_GRANTED:
				if (!extBusRequestIn) begin // RL10
					mstState_r <= CSBA_OWN;
				end
			endcase
		end
	end

	// slave mode: request, hold until granted, release when idle
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			slvState_r <= CSBA_IDLE;
		end else if (modeMaster_r || !modeValid_r) begin
			slvState_r <= CSBA_IDLE;
		end else begin
			unique case (slvState_r)
			CSBA_IDLE:
				if (cacheCycReq) begin
					slvState_r <= CSBA_REQ;
				end
			CSBA_REQ:
				if (extBusGrantIn) begin // RL6
					slvState_r <= CSBA_OWNED;
				end
			// hand the bus back once nothing is queued, so others get a turn
			CSBA_OWNED:
				if (!extBusGrantIn) begin
					slvState_r <= CSBA_IDLE;
				end else if (!cycActive_r && !cacheCycReq) begin
					slvState_r <= CSBA_IDLE; // RL10
				end
			endcase
		end
	end

	// master keeps driving through a drain; slave needs the grant still up
	assign ownBus = modeValid_r && (modeMaster_r ?
		(mstState_r != CSBA_GRANTED) :
		(slvState_r == CSBA_OWNED && extBusGrantIn)); // RL6
	// no new cycle once a drain has started
	// the request is still up on the edge that shows done; without the done
	// term a held request would launch the same cycle twice
	assign cycStart = ownBus && !cycActive_r && cacheCycReq &&
		!cacheCycDone &&
		!(modeMaster_r && mstState_r == CSBA_DRAIN);

	// pin directions follow the strap value caught once after reset
	assign extBusRequestOut  = (slvState_r != CSBA_IDLE); // RL5 RL10
	assign extBusRequestOe_b = modeMaster_r || !modeValid_r; // RL5
	assign extBusGrantOut    = (mstState_r == CSBA_GRANTED); // RL2
	assign extBusGrantOe_b   = !(modeMaster_r && modeValid_r); // RL5
	// processor side is never held off by system-bus ownership
	assign cpuBusGrant       = 1'b0; // RL3

	// system-side cycle runs on its own, apart from the processor bus
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			cycActive_r   <= 1'b0;
			cycWrite_r    <= 1'b0;
			sysAddrOut    <= '0;
			sysDataOut    <= '0;
			cacheCycDone  <= 1'b0;
			cacheCycRdata <= '0;
		end else begin
			cacheCycDone <= 1'b0;
			if (cycStart) begin // RL7
				cycActive_r <= 1'b1;
				cycWrite_r  <= cacheCycWrite;
				sysAddrOut  <= cacheCycAddr;
				sysDataOut  <= cacheCycWdata;
			end else if (cycActive_r && sysReady) begin
				cycActive_r   <= 1'b0;
				cacheCycDone  <= 1'b1;
				cacheCycRdata <= sysDataIn;
			end
		end
	end

	assign sysStrobeOut = cycActive_r;
	assign sysWriteOut  = cycWrite_r;
	assign sysCtlOe_b   = !ownBus; // RL6
	assign sysDataOe_b  = !(ownBus && cycActive_r && cycWrite_r);

	// snoop: capture foreign write, look up next cycle
	// address is taken every cycle; only the pending flag qualifies it
	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			snoopPend_r <= 1'b0;
			snoopAddr_r <= '0;
		end else begin
			snoopPend_r <= !ownBus && sysStrobeIn && sysWriteIn; // RL8
			snoopAddr_r <= sysAddrIn;
		end
	end

	assign dirIdx = idxOf(snoopAddr_r); // RL8

	always_ff @(posedge clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			dirInvalidate <= 1'b0;
			dirInvalIdx   <= '0;
		end else begin
			// tag compare covers the full address; index bits agree by construction
			// back-to-back hits simply pulse again, one per snooped write
			dirInvalidate <= snoopPend_r && dirValid &&
				(dirTag == snoopAddr_r); // RL9
			dirInvalIdx   <= idxOf(snoopAddr_r);
		end
	end
endmodule
`default_nettype wire

// File: testbench/csba_monitor.sv
// csba_monitor: port assertions for csba_arbiter
// assumes one clock; bound into each arbiter
`timescale 1ns/100ps
`default_nettype none
module csba_monitor #(
	parameter int unsigned ADDR_W = 32,
	parameter int unsigned IDX_W  = 8
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              modeStrap,
	input  wire logic              extBusRequestIn,
	input  wire logic              extBusGrantIn,
	input  wire logic              extBusRequestOut,
	input  wire logic              extBusRequestOe_b,
	input  wire logic              extBusGrantOut,
	input  wire logic              extBusGrantOe_b,
	input  wire logic              cpuBusGrant,
	input  wire logic              sysStrobeOut,
	input  wire logic              sysCtlOe_b,
	input  wire logic              sysStrobeIn,
	input  wire logic              sysWriteIn,
	input  wire logic              dirValid,
	input  wire logic              dirInvalidate,
	input  wire logic [ADDR_W-1:0] sysAddrIn,
	input  wire logic [ADDR_W-1:0] dirTag,
	input  wire logic [IDX_W-1:0]  dirIdx
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// a write is foreign only while we are off the bus
	sequence snoop; sysStrobeIn && sysWriteIn && sysCtlOe_b; endsequence
	a_mode_pins: assert property (
		!extBusGrantOe_b |-> modeStrap && extBusRequestOe_b) else $error("pins");
	a_slave_drive: assert property (
		!modeStrap && $fell(sysCtlOe_b) |-> $past(extBusGrantIn)
		&& $past(extBusRequestOut)) else $error("drive");
	a_grant_release: assert property (
		extBusGrantOut |-> sysCtlOe_b && !sysStrobeOut) else $error("release");
	a_grant_cause: assert property (
		$rose(extBusGrantOut) |-> $past(extBusRequestIn)) else $error("cause");
	a_grant_drop: assert property (
		extBusGrantOut && !extBusRequestIn |-> ##[1:2] !extBusGrantOut)
		else $error("drop");
	a_cpu_free: assert property (!cpuBusGrant) else $error("cpu");
	a_snoop_index: assert property (
		snoop |=> dirIdx == $past(sysAddrIn[IDX_W+1:2])) else $error("index");
	a_snoop_inval: assert property (
		snoop ##1 dirValid && dirTag == $past(sysAddrIn) |=> dirInvalidate)
		else $error("inval");
	a_own_nosnoop: assert property (
		sysStrobeIn && sysWriteIn && !sysCtlOe_b |-> ##2 !dirInvalidate)
		else $error("own write snooped");
	a_inval_cause: assert property (
		dirInvalidate |-> $past(dirValid) && $past(sysCtlOe_b, 2)
		&& $past(sysStrobeIn, 2) && $past(sysWriteIn, 2)
		&& $past(dirTag) == $past(sysAddrIn, 2)) else $error("inval cause");
	a_req_hold: assert property (
		extBusRequestOut && !extBusRequestOe_b && !extBusGrantIn
		|=> extBusRequestOut) else $error("req hold");
endmodule
bind csba_arbiter csba_monitor #(
	.ADDR_W(ADDR_W),
	.IDX_W (IDX_W)
) u_mon (
	.clk              (clk),
	.rst_b            (rst_b),
	.modeStrap        (modeStrap),
	.extBusRequestIn  (extBusRequestIn),
	.extBusGrantIn    (extBusGrantIn),
	.extBusRequestOut (extBusRequestOut),
	.extBusRequestOe_b(extBusRequestOe_b),
	.extBusGrantOut   (extBusGrantOut),
	.extBusGrantOe_b  (extBusGrantOe_b),
	.cpuBusGrant      (cpuBusGrant),
	.sysStrobeOut     (sysStrobeOut),
	.sysCtlOe_b       (sysCtlOe_b),
	.sysStrobeIn      (sysStrobeIn),
	.sysWriteIn       (sysWriteIn),
	.dirValid         (dirValid),
	.dirInvalidate    (dirInvalidate),
	.sysAddrIn        (sysAddrIn),
	.dirTag           (dirTag),
	.dirIdx           (dirIdx)
);
`default_nettype wire

// File: testbench/csba_sys_model.sv
// csba_sys_model: far-side master and system memory
// assumes nets named as the arbiter ports
`timescale 1ns/100ps
`default_nettype none
module csba_sys_model (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        extBusRequestOut,
	input  wire logic        extBusRequestOe_b,
	input  wire logic        sysStrobeOut,
	input  wire logic [1:0]  waits,
	output logic             extBusGrantIn,
	output logic             sysReady,
	output logic [31:0]      sysDataIn
);
	logic [1:0] cnt_r;
	wire logic last = sysStrobeOut && !sysReady && cnt_r == waits;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{extBusGrantIn, sysReady, cnt_r, sysDataIn} <= '0;
		end else begin
			extBusGrantIn <= extBusRequestOut && !extBusRequestOe_b;
			sysReady <= last;
			cnt_r <= (sysStrobeOut && !last && !sysReady) ? cnt_r + 2'h1 : 2'h0;
			// released bus data toggles so a read one cycle late never matches
			sysDataIn <= last ? 32'h5a5a00c3 : ~sysDataIn;
		end
	end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// tb_top: arbitration and snoop scenarios for csba_arbiter
// assumes csba_sys_model as the far side
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, rst_b = 1'b0, modeStrap, extBusRequestIn = 1'b0;
	logic cacheCycReq = 1'b0, cacheCycWrite = 1'b0, sysStrobeIn = 1'b0;
	logic sysWriteIn = 1'b0, dirValid = 1'b0;
	logic [1:0] waits = 2'h0;
	logic [31:0] cacheCycAddr = '0, cacheCycWdata = '0, sysAddrIn = '0, dirTag;
	wire logic extBusRequestOut, extBusRequestOe_b, extBusGrantIn, sysReady;
	wire logic extBusGrantOut, extBusGrantOe_b, cacheCycDone, cpuBusGrant;
	wire logic sysDataOe_b, sysStrobeOut, sysWriteOut, sysCtlOe_b, dirInvalidate;
	wire logic [31:0] cacheCycRdata, sysAddrOut, sysDataOut, sysDataIn;
	wire logic [7:0] dirIdx, dirInvalIdx;
	int n_fail = 0, num_checks = 0, cyc = 0, i;
	csba_arbiter u_csba_arbiter (.*);
	csba_sys_model u_csba_sys_model (.*);
	always #5 clk = ~clk;
	always @(posedge clk) if (++cyc == 2000) begin
		n_fail++;
		close_out();
	end
	task automatic chk(input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %0t %h %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic boot(input logic mode);
		modeStrap <= mode;
		rst_b <= 1'b0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk);
	endtask
	task automatic t_master();
		boot(1'b1);
		cacheCycAddr <= 32'h104;
		cacheCycReq <= 1'b1;
		@(posedge clk) extBusRequestIn <= 1'b1;
		for (i = 0; i < 20 && cacheCycDone !== 1'b1; i++) @(posedge clk);
		cacheCycReq <= 1'b0;
		chk(cacheCycRdata, 32'h5a5a00c3);
		for (i = 0; i < 20 && extBusGrantOut !== 1'b1; i++) @(posedge clk);
		chk({extBusGrantOe_b, sysCtlOe_b, cpuBusGrant}, 3'b010);
		sysAddrIn <= 32'ha08;
		dirTag <= 32'ha08;
		{sysStrobeIn, sysWriteIn, dirValid} <= 3'b111;
		@(posedge clk) sysStrobeIn <= 1'b0;
		repeat (2) @(posedge clk);
		chk({dirInvalidate, dirIdx, dirInvalIdx}, 17'h18282);
		extBusRequestIn <= 1'b0;
		repeat (3) @(posedge clk);
		chk(extBusGrantOut, 1'b0);
		sysStrobeIn <= 1'b1;
		@(posedge clk) sysStrobeIn <= 1'b0;
		repeat (2) @(posedge clk);
		chk(dirInvalidate, 1'b0);
	endtask
	task automatic t_slave();
		boot(1'b0);
		waits <= 2'h3;
		chk({extBusRequestOe_b, extBusGrantOe_b, sysCtlOe_b}, 3'b011);
		cacheCycWrite <= 1'b1;
		cacheCycAddr <= 32'h340;
		cacheCycWdata <= 32'hc3a51e0f;
		cacheCycReq <= 1'b1;
		for (i = 0; i < 20 && sysStrobeOut !== 1'b1; i++) @(posedge clk);
		chk(sysAddrOut, 32'h340);
		chk({sysWriteOut, sysDataOe_b, extBusGrantIn}, 3'b101);
		chk(sysDataOut, 32'hc3a51e0f);
		chk(extBusRequestOut, 1'b1);
		for (i = 0; i < 20 && cacheCycDone !== 1'b1; i++) @(posedge clk);
		chk(cacheCycDone, 1'b1);
		cacheCycReq <= 1'b0;
		modeStrap <= 1'b1;
		repeat (4) @(posedge clk);
		chk({extBusRequestOut, sysCtlOe_b}, 2'b01);
		chk({extBusRequestOe_b, extBusGrantOe_b}, 2'b01);
	endtask
	initial begin
		t_master();
		t_slave();
		close_out();
	end
endmodule
`default_nettype wire
